// ==== rtl/p2pc_pkg.sv ====
package p2pc_pkg;
  // ----------------------------------------------------------------
  // register offsets on the plain register port
  // ----------------------------------------------------------------
  localparam logic [3:0] P2PC_OFF_DATA  = 4'h0;  // output data / pin read
  localparam logic [3:0] P2PC_OFF_DIR   = 4'h1;  // direction, write only
  localparam logic [3:0] P2PC_OFF_FUNC  = 4'h2;  // pin function register
  localparam logic [3:0] P2PC_OFF_ODSEL = 4'h3;  // open-drain select
  localparam logic [3:0] P2PC_OFF_MODE  = 4'h4;  // power mode control
  // ----------------------------------------------------------------
  // field positions of the pin function register
  // ----------------------------------------------------------------
  localparam int P2PC_FN_SCK  = 0;  // serial clock select
  localparam int P2PC_FN_SI   = 1;  // serial input select
  localparam int P2PC_FN_SO   = 2;  // serial output select
  localparam int P2PC_FN_POF  = 5;  // serial output pmos disable
  // ----------------------------------------------------------------
  // reset values and read constants
  // ----------------------------------------------------------------
  localparam logic [7:0] P2PC_RST_DATA  = 8'h00;
  localparam logic [7:0] P2PC_RST_DIR   = 8'h00;
  localparam logic [7:0] P2PC_RST_ODSEL = 8'h00;
  localparam logic [7:0] P2PC_FN_FIXED  = 8'hD8;  // reserved bits read as one
  localparam logic [7:0] P2PC_DIR_READ  = 8'hFF;  // direction reads all ones
  localparam logic [7:0] P2PC_ZERO      = 8'h00;
  localparam int         P2PC_PULLUP_PIN = 4;
  // ----------------------------------------------------------------
  // operating modes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    P2PC_ACTIVE    = 3'b000,
    P2PC_SUBACTIVE = 3'b001,
    P2PC_SLEEP     = 3'b010,
    P2PC_SUBSLEEP  = 3'b011,
    P2PC_WATCH     = 3'b100,
    P2PC_STANDBY   = 3'b101
  } p2pc_mode_t;
endpackage

// ==== rtl/p2pc_pin_hold.sv ====
`timescale 1ns/1ps
`default_nettype none
// holds the pin drive image while the port is frozen
module p2pc_pin_hold
  import p2pc_pkg::*;
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // live drive image
  input  wire logic       freeze,
  input  wire logic [7:0] live_out,
  input  wire logic [7:0] live_oe_n,
  // held drive image
  output logic      [7:0] held_out,
  output logic      [7:0] held_oe_n
);
  logic [7:0] next_held_out;   // next output level
  logic [7:0] next_held_oe_n;  // next enable, low drives

  // ----------------------------------------------------------------
  // next value: track live image unless frozen
  // ----------------------------------------------------------------
  always_comb begin
    if (freeze) begin
      next_held_out  = held_out;
      next_held_oe_n = held_oe_n;
    end else begin
      next_held_out  = live_out;
      next_held_oe_n = live_oe_n;
    end
  end

  // registers; reset releases every pin
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      held_out  <= P2PC_ZERO;
      held_oe_n <= P2PC_DIR_READ;
    end else begin
      held_out  <= next_held_out;
      held_oe_n <= next_held_oe_n;
    end
  end
endmodule // p2pc_pin_hold
`default_nettype wire

// ==== rtl/p2pc_port_two_pin_control.sv ====
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - readable writable open-drain select, resets to zero
// - select bit chooses push-pull or open-drain
// - pins seven to three follow direction bit
// - function bits hand pins two..zero to serial
// - reset/standby float, sleep modes hold, else functional
// - flash variant pulls pin four up in reset
// - other variants float pin four in reset
// - port read returns data or live pin
// - direction write only, reads ones, resets zero
// - function bits zero..two select serial clock/in/out
// - separate bit makes serial output open-drain
module p2pc_port_two_pin_control
  import p2pc_pkg::*;
#(
  parameter bit FLASH_VARIANT = 1'b0  // flash part has the reset pull-up
)(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // register port
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // port pins, enable low while driving
  input  wire logic [7:0] pin_in,
  output logic      [7:0] pin_out,
  output logic      [7:0] pin_oe_n,
  output logic            pin4_pullup,
  // serial unit side
  input  wire logic       ser_out_data,
  input  wire logic       ser_clk_out,
  input  wire logic       ser_clk_oe,
  output logic            ser_in_data,
  output logic            ser_clk_in
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] pin_output_data_reg;        // stored output data
  logic [7:0] pin_direction_reg;          // one makes an output
  logic [7:0] open_drain_select;          // per-pin open-drain bit
  logic       serial_clock_select;        // pin 0 to serial clock
  logic       serial_in_select;           // pin 1 to serial input
  logic       serial_out_select;          // pin 2 to serial output
  logic       serial_out_pmos_disable;    // serial output open-drain
  p2pc_mode_t mode;                       // power mode from system
  logic [7:0] next_pin_output_data_reg;
  logic [7:0] next_pin_direction_reg;
  logic [7:0] next_open_drain_select;
  logic       next_serial_clock_select;
  logic       next_serial_in_select;
  logic       next_serial_out_select;
  logic       next_serial_out_pmos_disable;
  p2pc_mode_t next_mode;
  logic [7:0] next_reg_rdata;
  logic [7:0] live_out;                   // drive image before hold
  logic [7:0] live_oe_n;
  logic [7:0] held_out;
  logic [7:0] held_oe_n;
  logic       freeze;                     // sleep family holds pins
  logic       float_all;                  // standby releases pins

  // open-drain pins only ever pull low; a one releases the pin
  function automatic logic [1:0] drive(input logic val, input logic od);
    if (od) drive = {1'b0, val};
    else    drive = {val, 1'b0};
  endfunction

  // pin function register image with reserved bits set
  function automatic logic [7:0] func_image(input logic pof, input logic so,
                                            input logic si, input logic sck);
    logic [7:0] v;
    v = P2PC_FN_FIXED;
    v[P2PC_FN_POF] = pof;
    v[P2PC_FN_SO]  = so;
    v[P2PC_FN_SI]  = si;
    v[P2PC_FN_SCK] = sck;
    func_image = v;
  endfunction

  // ----------------------------------------------------------------
  // register writes and read data
  // ----------------------------------------------------------------
  always_comb begin
    next_pin_output_data_reg     = pin_output_data_reg;
    next_pin_direction_reg       = pin_direction_reg;
    next_open_drain_select       = open_drain_select;
    next_serial_clock_select     = serial_clock_select;
    next_serial_in_select        = serial_in_select;
    next_serial_out_select       = serial_out_select;
    next_serial_out_pmos_disable = serial_out_pmos_disable;
    next_mode                    = mode;
    next_reg_rdata               = P2PC_ZERO;
    if (reg_wr) begin
      if (reg_addr == P2PC_OFF_DATA) begin
        next_pin_output_data_reg = reg_wdata;
      end else if (reg_addr == P2PC_OFF_DIR) begin
        next_pin_direction_reg = reg_wdata;
      end else if (reg_addr == P2PC_OFF_FUNC) begin
        next_serial_clock_select     = reg_wdata[P2PC_FN_SCK];
        next_serial_in_select        = reg_wdata[P2PC_FN_SI];
        next_serial_out_select       = reg_wdata[P2PC_FN_SO];
        next_serial_out_pmos_disable = reg_wdata[P2PC_FN_POF];
      end else if (reg_addr == P2PC_OFF_ODSEL) begin
        next_open_drain_select = reg_wdata;
      end else if (reg_addr == P2PC_OFF_MODE) begin
        // unknown codes fall back to active
        case (reg_wdata[2:0])
          3'b001:  next_mode = P2PC_SUBACTIVE;
          3'b010:  next_mode = P2PC_SLEEP;
          3'b011:  next_mode = P2PC_SUBSLEEP;
          3'b100:  next_mode = P2PC_WATCH;
          3'b101:  next_mode = P2PC_STANDBY;
          default: next_mode = P2PC_ACTIVE;
        endcase
      end
    end
    if (reg_rd) begin
      if (reg_addr == P2PC_OFF_DATA) begin
        next_reg_rdata = (pin_direction_reg & pin_output_data_reg) |
                         (~pin_direction_reg & pin_in);
      end else if (reg_addr == P2PC_OFF_DIR) begin
        next_reg_rdata = P2PC_DIR_READ;
      end else if (reg_addr == P2PC_OFF_FUNC) begin
        next_reg_rdata = func_image(serial_out_pmos_disable, serial_out_select,
                                    serial_in_select, serial_clock_select);
      end else if (reg_addr == P2PC_OFF_ODSEL) begin
        next_reg_rdata = open_drain_select;
      end else if (reg_addr == P2PC_OFF_MODE) begin
        next_reg_rdata = {5'h0_0, mode};
      end
    end
  end

  // registers, all cleared by reset
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pin_output_data_reg     <= P2PC_RST_DATA;
      pin_direction_reg       <= P2PC_RST_DIR;
      open_drain_select       <= P2PC_RST_ODSEL;
      serial_clock_select     <= 1'b0;
      serial_in_select        <= 1'b0;
      serial_out_select       <= 1'b0;
      serial_out_pmos_disable <= 1'b0;
      mode                    <= P2PC_ACTIVE;
      reg_rdata               <= P2PC_ZERO;
    end else begin
      pin_output_data_reg     <= next_pin_output_data_reg;
      pin_direction_reg       <= next_pin_direction_reg;
      open_drain_select       <= next_open_drain_select;
      serial_clock_select     <= next_serial_clock_select;
      serial_in_select        <= next_serial_in_select;
      serial_out_select       <= next_serial_out_select;
      serial_out_pmos_disable <= next_serial_out_pmos_disable;
      mode                    <= next_mode;
      reg_rdata               <= next_reg_rdata;
    end
  end

  // ----------------------------------------------------------------
  // live pin drive image
  // ----------------------------------------------------------------
  always_comb begin
    logic [1:0] d;
    d = 2'b00;
    live_out  = P2PC_ZERO;
    live_oe_n = P2PC_DIR_READ;
    for (int i = 3; i < 8; i++) begin
      if (pin_direction_reg[i]) begin
        d = drive(pin_output_data_reg[i], open_drain_select[i]);
        live_out[i]  = d[1];
        live_oe_n[i] = d[0];
      end
    end
    if (serial_out_select) begin
      d = drive(ser_out_data, serial_out_pmos_disable);
      live_out[2]  = d[1];
      live_oe_n[2] = d[0];
    end else if (pin_direction_reg[2]) begin
      d = drive(pin_output_data_reg[2], open_drain_select[2]);
      live_out[2]  = d[1];
      live_oe_n[2] = d[0];
    end
    // pin 1 serial input, never driven
    if (!serial_in_select && pin_direction_reg[1]) begin
      d = drive(pin_output_data_reg[1], open_drain_select[1]);
      live_out[1]  = d[1];
      live_oe_n[1] = d[0];
    end
    if (serial_clock_select) begin
      live_out[0]  = ser_clk_out;
      live_oe_n[0] = ~ser_clk_oe;
    end else if (pin_direction_reg[0]) begin
      d = drive(pin_output_data_reg[0], open_drain_select[0]);
      live_out[0]  = d[1];
      live_oe_n[0] = d[0];
    end
  end

  assign freeze    = (mode == P2PC_SLEEP) || (mode == P2PC_SUBSLEEP) ||
                     (mode == P2PC_WATCH);
  assign float_all = (mode == P2PC_STANDBY);

  // holding stage keeps last image while the core sleeps
  p2pc_pin_hold u_hold (
    .core_clk  (core_clk),
    .rst       (rst),
    .freeze    (freeze),
    .live_out  (live_out),
    .live_oe_n (live_oe_n),
    .held_out  (held_out),
    .held_oe_n (held_oe_n)
  );

  // ----------------------------------------------------------------
  // pin outputs and serial returns
  // ----------------------------------------------------------------
  // standby floats every pin
  assign pin_out  = float_all ? P2PC_ZERO : held_out;
  assign pin_oe_n = float_all ? P2PC_DIR_READ : held_oe_n;
  assign pin4_pullup = FLASH_VARIANT & rst;
  assign ser_in_data = serial_in_select & pin_in[1];
  assign ser_clk_in  = serial_clock_select & pin_in[0];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  direction_read_a: assert property (
    reg_rd && reg_addr == P2PC_OFF_DIR |=> reg_rdata == P2PC_DIR_READ)
    else $error("direction read not all ones");
  // write, one idle cycle, then read back; data stands the cycle after
  odsel_roundtrip_a: assert property (
    reg_wr && reg_addr == P2PC_OFF_ODSEL ##1 !(reg_wr && reg_addr == P2PC_OFF_ODSEL)
    ##1 reg_rd && reg_addr == P2PC_OFF_ODSEL |=> reg_rdata == $past(reg_wdata, 3))
    else $error("open-drain select lost");
  port_read_a: assert property (
    reg_rd && reg_addr == P2PC_OFF_DATA |=> reg_rdata ==
    (($past(pin_direction_reg) & $past(pin_output_data_reg)) |
     (~$past(pin_direction_reg) & $past(pin_in))))
    else $error("port read mixes wrong sources");
  // both cycles running, else the hold stage may still show an old drive
  input_float_a: assert property (
    !pin_direction_reg[5] && mode == P2PC_ACTIVE ##1
    !pin_direction_reg[5] && mode == P2PC_ACTIVE |-> pin_oe_n[5])
    else $error("input pin driven");
  od_high_a: assert property (
    pin_direction_reg[6] && open_drain_select[6] && pin_output_data_reg[6] &&
    mode == P2PC_ACTIVE |=> mode != P2PC_ACTIVE || pin_oe_n[6])
    else $error("open-drain one drives");
  cmos_drive_a: assert property (
    pin_direction_reg[7] && !open_drain_select[7] && mode == P2PC_ACTIVE
    |=> mode != P2PC_ACTIVE || !pin_oe_n[7])
    else $error("push-pull output not driven");
  serial_in_a: assert property (
    serial_in_select |=> pin_oe_n[1] || $past(mode) != P2PC_ACTIVE)
    else $error("serial input pin driven");
  standby_float_a: assert property (
    mode == P2PC_STANDBY |-> pin_oe_n == P2PC_DIR_READ)
    else $error("standby pin driven");
  sleep_hold_a: assert property (
    mode == P2PC_SLEEP && $past(mode) == P2PC_SLEEP |-> $stable(pin_oe_n) && $stable(pin_out))
    else $error("sleep pin changed");
  func_reset_a: assert property (
    $fell(rst) |-> !serial_out_select && !serial_in_select)
    else $error("function bits not reset");
  // no pull-up unless flash build
  // pull-up follows reset itself, so reset must not disable this check
  reset_pullup_a: assert property (
    disable iff (1'b0) pin4_pullup == (FLASH_VARIANT && rst))
    else $error("pin four pull-up wrong");
  serial_od_a: assert property (
    serial_out_select && serial_out_pmos_disable && ser_out_data && mode == P2PC_ACTIVE
    |=> mode != P2PC_ACTIVE || pin_oe_n[2])
    else $error("serial open-drain one drives");

  serial_mode_c:  cover property (serial_out_select && serial_clock_select);
  od_mode_c:      cover property (open_drain_select != P2PC_ZERO && pin_direction_reg != P2PC_ZERO);
  standby_c:      cover property (mode == P2PC_STANDBY);
  sleep_hold_c:   cover property (mode == P2PC_WATCH ##1 mode == P2PC_ACTIVE);
endmodule // p2pc_port_two_pin_control
`default_nettype wire

// ==== tb/p2pc_far_side.sv ====
`timescale 1ns/1ps
`default_nettype none
// board wiring and serial unit stand-in beside the port
module p2pc_far_side (
  // pins from the port
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe_n,
  // board level seen on released pins (external pulls)
  input  wire logic [7:0] ext_level,
  // serial unit stimulus: enable, clock, data
  input  wire logic [2:0] ser_ctl,
  // back to the port
  output logic      [7:0] pin_in,
  output logic            ser_out_data,
  output logic            ser_clk_out,
  output logic            ser_clk_oe
);
  // ----------------------------------------------------------------
  // wire resolution
  // ----------------------------------------------------------------
  // a driven pin shows the port's level, a released one the board pull,
  // so an open-drain high never reads back the stored data by accident
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_level);
  // serial unit only presents what the bench asks for
  assign ser_out_data = ser_ctl[0];
  assign ser_clk_out  = ser_ctl[1];
  assign ser_clk_oe   = ser_ctl[2];
endmodule // p2pc_far_side
`default_nettype wire

// ==== tb/p2pc_port_two_pin_control_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module p2pc_port_two_pin_control_test
  import p2pc_pkg::*;
;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic       core_clk;     // 20 MHz
  logic       rst;          // async, high
  logic [3:0] reg_addr;     // register index
  logic [7:0] reg_wdata;    // write data
  logic       reg_wr;       // write strobe
  logic       reg_rd;       // read strobe
  logic [7:0] reg_rdata;    // read data
  logic [7:0] pin_in;       // resolved pin levels
  logic [7:0] pin_out;      // pin drive level
  logic [7:0] pin_oe_n;     // low while driving
  logic       pin4_pullup;  // reset pull-up
  logic       ser_out_data; // serial data out
  logic       ser_clk_out;  // serial clock drive
  logic       ser_clk_oe;   // serial clock enable
  logic       ser_in_data;  // serial data in
  logic       ser_clk_in;   // serial clock in
  logic       flash_pullup; // flash build pull-up
  logic [7:0] ext_level;    // board level
  logic [2:0] ser_ctl;      // serial stimulus
  logic [7:0] img;          // last functional pin image
  int         mismatches;
  int         checks_done;
  // ----------------------------------------------------------------
  // instances
  // ----------------------------------------------------------------
  p2pc_port_two_pin_control #(.FLASH_VARIANT(1'b0)) dut_u (
    .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin4_pullup(pin4_pullup),
    .ser_out_data(ser_out_data), .ser_clk_out(ser_clk_out), .ser_clk_oe(ser_clk_oe),
    .ser_in_data(ser_in_data), .ser_clk_in(ser_clk_in));
  p2pc_far_side far_u (
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_level(ext_level), .ser_ctl(ser_ctl),
    .pin_in(pin_in), .ser_out_data(ser_out_data), .ser_clk_out(ser_clk_out),
    .ser_clk_oe(ser_clk_oe));
  // flash build, watched only for its reset pull-up
  p2pc_port_two_pin_control #(.FLASH_VARIANT(1'b1)) flash_u (
    .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(), .pin_in(pin_in),
    .pin_out(), .pin_oe_n(), .pin4_pullup(flash_pullup),
    .ser_out_data(ser_out_data), .ser_clk_out(ser_clk_out), .ser_clk_oe(ser_clk_oe),
    .ser_in_data(), .ser_clk_in());
  // ----------------------------------------------------------------
  // clock and watchdog
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // run needs under two hundred cycles, about 9 us; 100 us leaves a wide margin
  initial begin
    #100000;
    mismatches++;
    give_verdict();
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask
  // data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  // config reaches the pins through one register stage
  task automatic settle();
    repeat (2) @(posedge core_clk);
    #1;
  endtask
  // drive level is compared only where the pin is driven
  task automatic pins(input logic [7:0] eout, input logic [7:0] eoe);
    chk(pin_out & ~eoe, eout & ~eoe);
    chk(pin_oe_n, eoe);
  endtask
  task automatic run_mode(input p2pc_mode_t md, input logic [7:0] v);
    logic hold;
    hold = md inside {P2PC_SLEEP, P2PC_SUBSLEEP, P2PC_WATCH};
    wr(P2PC_OFF_MODE, {5'h00, md});
    settle();
    rd(P2PC_OFF_MODE, {5'h00, md}); // mode readback
    wr(P2PC_OFF_DATA, v);
    settle();
    if (md == P2PC_STANDBY) begin
      chk(pin_oe_n, 8'hFF); // standby float
    end else begin
      pins(hold ? img : v, 8'h00); // hold or run
    end
    wr(P2PC_OFF_MODE, {5'h00, P2PC_ACTIVE});
    settle();
    pins(v, 8'h00); // back to run
    img = v;
  endtask
  task automatic give_verdict();
    if (mismatches == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    ext_level = 8'h3E;
    ser_ctl = 3'h0;
    mismatches = 0;
    checks_done = 0;
    repeat (5) @(posedge core_clk);
    #1 chk(pin_oe_n, 8'hFF); // reset float
    chk({7'h00, pin4_pullup}, 8'h00); // no pull-up
    chk({7'h00, flash_pullup}, 8'h01); // flash pull-up
    @(posedge core_clk);
    rst <= 1'b0;
    rd(P2PC_OFF_ODSEL, 8'h00); // odsel reset
    chk({7'h00, flash_pullup}, 8'h00); // pull-up off after reset
    rd(P2PC_OFF_DIR, 8'hFF); // dir reads ones
    rd(P2PC_OFF_FUNC, 8'hD8); // function reset
    rd(P2PC_OFF_DATA, 8'h3E); // inputs read live
    wr(P2PC_OFF_ODSEL, 8'hA5);
    rd(P2PC_OFF_ODSEL, 8'hA5); // odsel readback
    wr(4'hF, 8'hFF);
    rd(4'hF, 8'h00); // unmapped reads zero
    rd(P2PC_OFF_ODSEL, 8'hA5); // unmapped write ignored
    // direction, drive type and port read
    wr(P2PC_OFF_DIR, 8'hF0);
    wr(P2PC_OFF_ODSEL, 8'hF0);
    wr(P2PC_OFF_DATA, 8'h5A);
    settle();
    pins(8'h00, 8'h5F); // open-drain high nibble
    rd(P2PC_OFF_DATA, 8'h5E); // data or live pin
    rd(P2PC_OFF_DIR, 8'hFF); // dir still reads ones
    wr(P2PC_OFF_ODSEL, 8'h00);
    settle();
    pins(8'h5A, 8'h0F); // push-pull, low nibble input
    wr(P2PC_OFF_DIR, 8'hFF);
    wr(P2PC_OFF_ODSEL, 8'h0F);
    settle();
    pins(8'h50, 8'h0A); // mixed drive types
    // serial takeover of pins two to zero
    // pins two..zero set as outputs, serial use must still win
    wr(P2PC_OFF_DIR, 8'h07);
    wr(P2PC_OFF_ODSEL, 8'h00);
    ser_ctl <= 3'b101;
    wr(P2PC_OFF_FUNC, 8'h07);
    settle();
    pins(8'h04, 8'hFA); // serial owns pins
    chk({6'h00, ser_in_data, ser_clk_in}, 8'h02); // serial inputs
    rd(P2PC_OFF_FUNC, 8'hDF); // function fields
    wr(P2PC_OFF_FUNC, 8'h27);
    ser_ctl <= 3'b100;
    settle();
    pins(8'h00, 8'hFA); // open-drain low
    ser_ctl <= 3'b101;
    settle();
    pins(8'h00, 8'hFE); // open-drain release
    rd(P2PC_OFF_FUNC, 8'hFF); // pmos disable bit
    wr(P2PC_OFF_FUNC, 8'h00);
    wr(P2PC_OFF_DIR, 8'hFF);
    img = 8'h5A;
    for (int m = 0; m < 6; m++) begin
      run_mode(p2pc_mode_t'(m), 8'(17 * (m + 1)));
    end
    // unknown mode codes fall back to active
    wr(P2PC_OFF_MODE, 8'h01);
    wr(P2PC_OFF_MODE, 8'h07);
    rd(P2PC_OFF_MODE, 8'h00); // refused code reads active
    // second reset while pins drive, registers made non-zero first
    wr(P2PC_OFF_ODSEL, 8'hC3);
    wr(P2PC_OFF_FUNC, 8'h27);
    @(posedge core_clk);
    rst <= 1'b1;
    settle();
    chk(pin_oe_n, 8'hFF); // reset float
    chk({7'h00, flash_pullup}, 8'h01); // flash pull-up
    chk({7'h00, pin4_pullup}, 8'h00); // no pull-up
    @(posedge core_clk);
    rst <= 1'b0;
    rd(P2PC_OFF_ODSEL, 8'h00); // odsel cleared
    rd(P2PC_OFF_FUNC, 8'hD8); // function cleared
    rd(P2PC_OFF_DATA, 8'h3E); // direction back to inputs
    rd(P2PC_OFF_MODE, 8'h00); // mode back to active
    chk({7'h00, flash_pullup}, 8'h00); // pull-up off again
    give_verdict();
  end
endmodule // p2pc_port_two_pin_control_test
`default_nettype wire
